// ===== rtl/ofs_pkg.sv
// constants and types shared by the operating-state fault sequencer
// Notes on behaviour
// - track seven operating states
// - any reset source forces reset state
// - cold boot inits analog, cpu held
// - cold boot end releases master cpu
// - warm boot fetches rom, memories secure
// - pre-operational runs application configuration and tests
// - operational reached only from pre-operational
// - primary subsystem alone starts secondary subsystem
// - critical error in either subsystem enters safe
// - safe state raises fault indication pins
// - fault responses graded by severity
// - unserviced master nmi asserts warm reset pin
// - cpu reset returns cpu to warm boot
// - security violation causes cpu reset
// - unserviced secondary nmi resets secondary cpu
// - nmi watchdog drives nmi with error pin
// - nmi outranks every other interrupt
// - expansion block multiplexes peripheral interrupts
// - power restore restarts from cold boot
// - power-on reset makes warm reset, open drain
package ofs_pkg;

  // ***************************************************
  // operating states
  // ***************************************************
  typedef enum logic [2:0] {
    OFS_POWERED_OFF,
    OFS_RESET,
    OFS_COLD_BOOT,
    OFS_WARM_BOOT,
    OFS_PRE_OPERATIONAL,
    OFS_OPERATIONAL,
    OFS_SAFE
  } ofs_state_t;

  // fault response grades, higher is more severe
  typedef enum logic [2:0] {
    OFS_SEV_NONE,
    OFS_SEV_CPU_INT,
    OFS_SEV_NMI,
    OFS_SEV_CPU_RESET,
    OFS_SEV_WARM_RESET,
    OFS_SEV_POWER_DOWN
  } ofs_sev_t;

  // ***************************************************
  // timing
  // ***************************************************
  localparam int OFS_CLK_MHZ          = 250;
  localparam int OFS_COLD_BOOT_NS     = 400;
  localparam int OFS_COLD_BOOT_CYC    = (OFS_COLD_BOOT_NS * OFS_CLK_MHZ + 999) / 1000;
  localparam int OFS_NMI_TIMEOUT_NS   = 4000;
  localparam int OFS_NMI_TIMEOUT_CYC  = (OFS_NMI_TIMEOUT_NS * OFS_CLK_MHZ) / 1000;
  localparam int OFS_WARM_PULSE_NS    = 200;
  localparam int OFS_WARM_PULSE_CYC   = (OFS_WARM_PULSE_NS * OFS_CLK_MHZ + 999) / 1000;

  // reset values and the nmi vector
  localparam logic [7:0] OFS_IRQ_RESET = 8'h00;
  localparam logic [4:0] OFS_VEC_NONE  = 5'h00;
  localparam logic [4:0] OFS_VEC_NMI   = 5'h1f;

endpackage

// ===== rtl/ofs_nmi_watchdog.sv
// nmi watchdog: raises nmi on a critical fault, escalates if unserviced
`timescale 1ns/1ns
module ofs_nmi_watchdog #(
  parameter int TIMEOUT_CYC = 1000
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // control
  input  wire logic enable,
  input  wire logic fault,
  input  wire logic nmi_ack,
  // status
  output logic      nmi,
  output logic      expired
);
  import ofs_pkg::*;

  localparam int CW = $clog2(TIMEOUT_CYC + 1);

  logic [CW-1:0] cnt_ff;
  logic          nmi_ff;
  logic          exp_ff;

  assign nmi     = nmi_ff;
  assign expired = exp_ff;

  // the fault wins over the acknowledge so no event is dropped
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      nmi_ff <= 1'b0;
    end else if (!enable) begin
      nmi_ff <= 1'b0;
    end else if (fault) begin
      nmi_ff <= 1'b1;
    end else if (nmi_ack) begin
      nmi_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
      exp_ff <= 1'b0;
    end else if (!enable || !nmi_ff) begin
      cnt_ff <= '0;
      exp_ff <= 1'b0;
    end else if (cnt_ff == CW'(TIMEOUT_CYC - 1)) begin
      exp_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + CW'(1);
    end
  end

endmodule // ofs_nmi_watchdog

// ===== rtl/ofs_sequencer.sv
// top of the operating-state fault sequencer
`timescale 1ns/1ns
module ofs_sequencer #(
  parameter int NUM_IRQ         = 8,
  parameter int NMI_TIMEOUT_CYC = ofs_pkg::OFS_NMI_TIMEOUT_CYC
) (
  // clock and power-on reset
  input  wire logic                clock,
  input  wire logic                nrst,
  // reset sources (pins asynchronous, internal synchronous)
  input  wire logic                warm_reset_pin_in,
  input  wire logic                int_reset_req,
  // boot progress from software
  input  wire logic                boot_rom_done,
  input  wire logic                app_config_done,
  input  wire logic                secure_cfg_done,
  input  wire logic                sec_start_req,
  // fault sources
  input  wire logic                pri_critical_fault,
  input  wire logic                sec_critical_fault,
  input  wire logic                pri_nmi_ack,
  input  wire logic                sec_nmi_ack,
  input  wire logic                security_violation,
  input  wire logic [NUM_IRQ-1:0]  periph_irq,
  input  wire logic                irq_ack,
  // state and cpu control
  output ofs_pkg::ofs_state_t      op_state,
  output ofs_pkg::ofs_state_t      sec_state,
  output logic                     init_analog,
  output logic                     master_cpu_reset,
  output logic                     secondary_cpu_reset,
  output logic                     fetch_boot_rom,
  output logic                     mem_secure,
  output logic                     safety_enable,
  output logic                     func_outputs_off,
  // interrupts
  output logic                     pri_nmi,
  output logic                     sec_nmi,
  output logic                     cpu_int,
  output logic [4:0]               cpu_int_vec,
  // fault pins
  output logic                     error_status_pin,
  output logic                     warm_reset_pin_out,
  output logic                     warm_reset_pin_oe,
  output ofs_pkg::ofs_sev_t        fault_severity
);
  import ofs_pkg::*;

  // ***************************************************
  // reset pin synchroniser (three flops, last two agree)
  // ***************************************************
  logic [2:0] pin_sync_ff;
  logic       pin_low_ff;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_sync_ff <= 3'h0;
    end else begin
      pin_sync_ff <= {pin_sync_ff[1:0], warm_reset_pin_in};
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_low_ff <= 1'b1;
    end else if (pin_sync_ff[2] == pin_sync_ff[1]) begin
      pin_low_ff <= ~pin_sync_ff[2];
    end
  end

  // ***************************************************
  // state registers
  // ***************************************************
  ofs_state_t  state_ff;
  ofs_state_t  nxt_state;
  ofs_state_t  sec_ff;
  ofs_state_t  nxt_sec;
  logic [$clog2(OFS_COLD_BOOT_CYC+1)-1:0] cold_cnt_ff;
  logic        cold_done;
  logic        warm_drive_ff;
  logic [$clog2(OFS_WARM_PULSE_CYC+1)-1:0] warm_cnt_ff;
  logic        any_reset;
  logic        pri_exp;
  logic        sec_exp;
  logic        pri_nmi_w;
  logic        sec_nmi_w;
  logic        pri_cpu_reset;
  logic        sec_cpu_reset;

  // internal pin drive loops back through the pin, so it also holds reset
  assign any_reset = pin_low_ff | int_reset_req | warm_drive_ff;
  assign cold_done = (cold_cnt_ff == '0);

  assign pri_cpu_reset = security_violation;
  assign sec_cpu_reset = security_violation | sec_exp;

  // ***************************************************
  // nmi watchdogs, one per subsystem
  // ***************************************************
  ofs_nmi_watchdog #(
    .TIMEOUT_CYC (NMI_TIMEOUT_CYC)
  ) u_pri_wd (
    .clock   (clock),
    .nrst    (nrst),
    .enable  (state_ff inside {OFS_PRE_OPERATIONAL, OFS_OPERATIONAL, OFS_SAFE}),
    .fault   (pri_critical_fault),
    .nmi_ack (pri_nmi_ack),
    .nmi     (pri_nmi_w),
    .expired (pri_exp)
  );

  ofs_nmi_watchdog #(
    .TIMEOUT_CYC (NMI_TIMEOUT_CYC)
  ) u_sec_wd (
    .clock   (clock),
    .nrst    (nrst),
    .enable  (sec_ff == OFS_OPERATIONAL),
    .fault   (sec_critical_fault),
    .nmi_ack (sec_nmi_ack),
    .nmi     (sec_nmi_w),
    .expired (sec_exp)
  );

  // ***************************************************
  // device state machine
  // ***************************************************
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      OFS_POWERED_OFF: begin
        nxt_state = OFS_RESET;
      end
      OFS_RESET: begin
        if (!any_reset) begin
          nxt_state = OFS_COLD_BOOT;
        end
      end
      OFS_COLD_BOOT: begin
        if (cold_done) begin
          nxt_state = OFS_WARM_BOOT;
        end
      end
      OFS_WARM_BOOT: begin
        if (boot_rom_done && secure_cfg_done) begin
          nxt_state = OFS_PRE_OPERATIONAL;
        end
      end
      OFS_PRE_OPERATIONAL: begin
        if (pri_cpu_reset) begin
          nxt_state = OFS_WARM_BOOT;
        end else if (pri_critical_fault) begin
          nxt_state = OFS_SAFE;
        end else if (app_config_done) begin
          nxt_state = OFS_OPERATIONAL;
        end
      end
      OFS_OPERATIONAL: begin
        if (pri_cpu_reset) begin
          nxt_state = OFS_WARM_BOOT;
        end else if (pri_critical_fault || sec_critical_fault) begin
          nxt_state = OFS_SAFE;
        end
      end
      OFS_SAFE: begin
        nxt_state = OFS_SAFE;
      end
      default: begin
        nxt_state = OFS_RESET;
      end
    endcase
    if (any_reset) begin
      nxt_state = OFS_RESET;
    end
  end

  // nrst models power-on: the device leaves powered-off at release
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_ff <= OFS_POWERED_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // cold boot length counter
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cold_cnt_ff <= ($clog2(OFS_COLD_BOOT_CYC+1))'(OFS_COLD_BOOT_CYC);
    end else if (state_ff != OFS_COLD_BOOT) begin
      cold_cnt_ff <= ($clog2(OFS_COLD_BOOT_CYC+1))'(OFS_COLD_BOOT_CYC);
    end else if (!cold_done) begin
      cold_cnt_ff <= cold_cnt_ff - 1'b1;
    end
  end

  // ***************************************************
  // secondary subsystem state
  // ***************************************************
  always_comb begin
    nxt_sec = sec_ff;
    unique case (sec_ff)
      OFS_RESET: begin
        if (state_ff == OFS_OPERATIONAL && sec_start_req) begin
          nxt_sec = OFS_WARM_BOOT;
        end
      end
      OFS_WARM_BOOT: begin
        nxt_sec = OFS_OPERATIONAL;
      end
      OFS_OPERATIONAL: begin
        if (sec_cpu_reset) begin
          nxt_sec = OFS_WARM_BOOT;
        end
      end
      default: begin
        nxt_sec = OFS_RESET;
      end
    endcase
    if (!(state_ff inside {OFS_PRE_OPERATIONAL, OFS_OPERATIONAL, OFS_SAFE})) begin
      nxt_sec = OFS_RESET;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sec_ff <= OFS_RESET;
    end else begin
      sec_ff <= nxt_sec;
    end
  end

  // ***************************************************
  // warm reset pin drive
  // ***************************************************
  // a stretched pulse so the external monitor sees the assertion
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      warm_drive_ff <= 1'b0;
      warm_cnt_ff   <= '0;
    end else if (pri_exp) begin
      warm_drive_ff <= 1'b1;
      warm_cnt_ff   <= ($clog2(OFS_WARM_PULSE_CYC+1))'(OFS_WARM_PULSE_CYC);
    end else if (warm_cnt_ff != '0) begin
      warm_cnt_ff   <= warm_cnt_ff - 1'b1;
    end else begin
      warm_drive_ff <= 1'b0;
    end
  end

  // ***************************************************
  // interrupt expansion: lowest line first, nmi above all
  // ***************************************************
  logic [NUM_IRQ-1:0] irq_pend_ff;
  logic [4:0]         nxt_vec;
  logic               nxt_int;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_pend_ff <= NUM_IRQ'(OFS_IRQ_RESET);
    end else begin
      // a new request beats an acknowledge in the same cycle
      irq_pend_ff <= periph_irq |
        (irq_pend_ff & ~(irq_ack && cpu_int_vec != OFS_VEC_NMI ?
                         (NUM_IRQ'(1) << cpu_int_vec) : NUM_IRQ'(0)));
    end
  end

  always_comb begin
    nxt_vec = OFS_VEC_NONE;
    nxt_int = 1'b0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (irq_pend_ff[i]) begin
        nxt_vec = 5'(i);
        nxt_int = 1'b1;
      end
    end
    if (pri_nmi_w) begin
      nxt_vec = OFS_VEC_NMI;
      nxt_int = 1'b1;
    end
  end

  // ***************************************************
  // severity grading
  // ***************************************************
  ofs_sev_t nxt_sev;

  always_comb begin
    if (warm_drive_ff || pri_exp) begin
      nxt_sev = OFS_SEV_WARM_RESET;
    end else if (pri_cpu_reset || sec_cpu_reset) begin
      nxt_sev = OFS_SEV_CPU_RESET;
    end else if (pri_nmi_w || sec_nmi_w) begin
      nxt_sev = OFS_SEV_NMI;
    end else if (|irq_pend_ff) begin
      nxt_sev = OFS_SEV_CPU_INT;
    end else begin
      nxt_sev = OFS_SEV_NONE;
    end
  end

  // ***************************************************
  // registered outputs
  // ***************************************************
  ofs_state_t out_state_ff;
  ofs_state_t out_sec_ff;
  ofs_sev_t   sev_ff;
  logic       init_ff;
  logic       mrst_ff;
  logic       srst_ff;
  logic       fetch_ff;
  logic       secure_ff;
  logic       safe_en_ff;
  logic       off_ff;
  logic       pnmi_ff;
  logic       snmi_ff;
  logic       int_ff;
  logic [4:0] vec_ff;
  logic       err_ff;
  logic       oe_ff;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      out_state_ff <= OFS_POWERED_OFF;
      out_sec_ff   <= OFS_RESET;
      init_ff      <= 1'b0;
      mrst_ff      <= 1'b1;
      srst_ff      <= 1'b1;
      fetch_ff     <= 1'b0;
      safe_en_ff   <= 1'b0;
      off_ff       <= 1'b1;
    end else begin
      out_state_ff <= state_ff;
      out_sec_ff   <= sec_ff;
      init_ff      <= (state_ff == OFS_COLD_BOOT);
      mrst_ff      <= (state_ff == OFS_POWERED_OFF || state_ff == OFS_RESET ||
                       state_ff == OFS_COLD_BOOT);
      srst_ff      <= (sec_ff == OFS_RESET);
      fetch_ff     <= (state_ff == OFS_WARM_BOOT);
      safe_en_ff   <= (state_ff == OFS_OPERATIONAL);
      off_ff       <= (state_ff == OFS_SAFE || state_ff == OFS_RESET ||
                       state_ff == OFS_POWERED_OFF);
    end
  end

  // memories secure from warm boot entry until boot code reconfigures
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      secure_ff <= 1'b1;
    end else if (state_ff == OFS_WARM_BOOT && out_state_ff != OFS_WARM_BOOT) begin
      secure_ff <= 1'b1;
    end else if (out_state_ff == OFS_WARM_BOOT && secure_cfg_done) begin
      secure_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pnmi_ff <= 1'b0;
      snmi_ff <= 1'b0;
      int_ff  <= 1'b0;
      vec_ff  <= OFS_VEC_NONE;
      err_ff  <= 1'b0;
      sev_ff  <= OFS_SEV_NONE;
    end else begin
      pnmi_ff <= pri_nmi_w;
      snmi_ff <= sec_nmi_w;
      int_ff  <= nxt_int;
      vec_ff  <= nxt_vec;
      err_ff  <= pri_nmi_w | sec_nmi_w | (state_ff == OFS_SAFE);
      sev_ff  <= nxt_sev;
    end
  end

  // open drain: power-on reset and escalation both pull the pin low
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      oe_ff <= 1'b1;
    end else begin
      oe_ff <= warm_drive_ff | (state_ff == OFS_POWERED_OFF);
    end
  end

  assign op_state            = out_state_ff;
  assign sec_state           = out_sec_ff;
  assign init_analog         = init_ff;
  assign master_cpu_reset    = mrst_ff;
  assign secondary_cpu_reset = srst_ff;
  assign fetch_boot_rom      = fetch_ff;
  assign mem_secure          = secure_ff;
  assign safety_enable       = safe_en_ff;
  assign func_outputs_off    = off_ff;
  assign pri_nmi             = pnmi_ff;
  assign sec_nmi             = snmi_ff;
  assign cpu_int             = int_ff;
  assign cpu_int_vec         = vec_ff;
  assign error_status_pin    = err_ff;
  assign warm_reset_pin_out  = 1'b0;
  assign warm_reset_pin_oe   = oe_ff;
  assign fault_severity      = sev_ff;

endmodule // ofs_sequencer

// ===== verif/ofs_sequencer_asserts.sv
// concurrent checks on the operating-state fault sequencer ports
`timescale 1ns/1ns
module ofs_sequencer_asserts
  import ofs_pkg::*;
(
  // clock and reset
  input wire logic       clock,
  input wire logic       nrst,
  // causes
  input wire logic       warm_reset_pin_in,
  input wire logic       int_reset_req,
  input wire logic       security_violation,
  // effects
  input wire ofs_state_t op_state,
  input wire logic       init_analog,
  input wire logic       master_cpu_reset,
  input wire logic       secondary_cpu_reset,
  input wire logic       fetch_boot_rom,
  input wire logic       mem_secure,
  input wire logic       safety_enable,
  input wire logic       func_outputs_off,
  input wire logic       pri_nmi,
  input wire logic       sec_nmi,
  input wire logic [4:0] cpu_int_vec,
  input wire logic       error_status_pin,
  input wire logic       warm_reset_pin_out,
  input wire logic       warm_reset_pin_oe,
  input wire ofs_sev_t   fault_severity
);
  localparam int COLD_LO = 99;
  localparam int COLD_HI = 101;

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  // ***************************************************
  // state sequence
  // ***************************************************
  property p_cold_hold;
    op_state == OFS_COLD_BOOT |-> master_cpu_reset && init_analog;
  endproperty
  a_cold_hold: assert property (p_cold_hold)
    else $error("cpu not held during cold boot");
  property p_cold_len;
    $changed(op_state) && op_state == OFS_COLD_BOOT |-> ##[COLD_LO:COLD_HI] op_state == OFS_WARM_BOOT;
  endproperty
  a_cold_len: assert property (p_cold_len)
    else $error("cold boot did not end in warm boot");
  property p_warm_entry;
    $changed(op_state) && op_state == OFS_WARM_BOOT |-> fetch_boot_rom && mem_secure && !master_cpu_reset;
  endproperty
  a_warm_entry: assert property (p_warm_entry)
    else $error("warm boot entered without rom fetch or secure memories");
  property p_op_from_pre;
    $changed(op_state) && op_state == OFS_OPERATIONAL |-> $past(op_state) == OFS_PRE_OPERATIONAL;
  endproperty
  a_op_from_pre: assert property (p_op_from_pre)
    else $error("operational entered from wrong state");
  property p_safety;
    safety_enable |-> op_state == OFS_OPERATIONAL;
  endproperty
  a_safety: assert property (p_safety)
    else $error("safety functions enabled outside operational");
  property p_sec_start;
    $fell(secondary_cpu_reset) |-> op_state == OFS_OPERATIONAL;
  endproperty
  a_sec_start: assert property (p_sec_start)
    else $error("secondary released outside operational");
  property p_leave_reset;
    op_state != OFS_RESET && $past(op_state) == OFS_RESET |-> op_state == OFS_COLD_BOOT;
  endproperty
  a_leave_reset: assert property (p_leave_reset)
    else $error("reset not followed by cold boot");
  property p_int_reset;
    int_reset_req |-> ##[1:3] op_state == OFS_RESET;
  endproperty
  a_int_reset: assert property (p_int_reset)
    else $error("internal reset source ignored");
  property p_pin_reset;
    !warm_reset_pin_in |-> ##[1:6] op_state == OFS_RESET;
  endproperty
  a_pin_reset: assert property (p_pin_reset)
    else $error("reset pin ignored");
  property p_secviol;
    security_violation && op_state == OFS_OPERATIONAL |-> ##[1:3] op_state == OFS_WARM_BOOT;
  endproperty
  a_secviol: assert property (p_secviol)
    else $error("security violation did not return to warm boot");

  // ***************************************************
  // fault indications
  // ***************************************************
  property p_safe_pins;
    op_state == OFS_SAFE |-> func_outputs_off || error_status_pin;
  endproperty
  a_safe_pins: assert property (p_safe_pins)
    else $error("safe state without indication");
  property p_nmi_err;
    pri_nmi || sec_nmi |-> error_status_pin && fault_severity >= OFS_SEV_NMI;
  endproperty
  a_nmi_err: assert property (p_nmi_err)
    else $error("nmi without error pin");
  property p_nmi_vec;
    pri_nmi |-> cpu_int_vec == OFS_VEC_NMI;
  endproperty
  a_nmi_vec: assert property (p_nmi_vec)
    else $error("nmi not at top priority");
  property p_warm_cause;
    $rose(warm_reset_pin_oe) |-> $past(pri_nmi) || pri_nmi;
  endproperty
  a_warm_cause: assert property (p_warm_cause)
    else $error("warm reset pin driven without master nmi");
  property p_open_drain;
    warm_reset_pin_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("reset pin driven high");

  c_operational: cover property (op_state == OFS_OPERATIONAL);
  c_safe: cover property (op_state == OFS_SAFE && pri_nmi);
  c_warm_pin: cover property ($rose(warm_reset_pin_oe));
endmodule // ofs_sequencer_asserts

bind ofs_sequencer ofs_sequencer_asserts u_chk (
  .clock(clock), .nrst(nrst), .warm_reset_pin_in(warm_reset_pin_in),
  .int_reset_req(int_reset_req), .security_violation(security_violation),
  .op_state(op_state), .init_analog(init_analog), .master_cpu_reset(master_cpu_reset),
  .secondary_cpu_reset(secondary_cpu_reset), .fetch_boot_rom(fetch_boot_rom),
  .mem_secure(mem_secure), .safety_enable(safety_enable), .func_outputs_off(func_outputs_off),
  .pri_nmi(pri_nmi), .sec_nmi(sec_nmi), .cpu_int_vec(cpu_int_vec),
  .error_status_pin(error_status_pin), .warm_reset_pin_out(warm_reset_pin_out),
  .warm_reset_pin_oe(warm_reset_pin_oe), .fault_severity(fault_severity));

// ===== verif/ofs_supervisor.sv
// external supervisor: device power and the pulled-up warm reset wire
`timescale 1ns/1ns
module ofs_supervisor (
  // commands from the bench
  input  wire logic power_cut,
  input  wire logic ext_reset,
  // device side
  input  wire logic pin_oe,
  output logic      nrst,
  output logic      pin_level
);
  // power may be removed in any device state
  assign nrst = !power_cut;
  // open-drain wire with pull-up: low when any party pulls
  assign pin_level = !(pin_oe || ext_reset);
endmodule // ofs_supervisor

// ===== verif/operating_state_fault_sequencer_test.sv
// self-checking bench for the operating-state fault sequencer
`timescale 1ns/1ns
module operating_state_fault_sequencer_test;
  import ofs_pkg::*;
  logic       clock = 1'b0;
  logic       power_cut, ext_reset, nrst, pin_level, rom_done, cfg_done, app_done, start_req;
  logic       int_req, pri_f, sec_f, pri_ack, sec_ack, sviol, iack, init_an, mcr, scr;
  logic       fetch, msec, safe_en, fo_off, pri_nmi, sec_nmi, cpu_int, err_pin, pin_out, pin_oe;
  logic [7:0] pirq;
  logic [4:0] vec;
  ofs_state_t op_state, sec_state;
  ofs_sev_t   sev;
  int         mismatches = 0;
  int         n_tests = 0;
  int         cycles = 0;

  ofs_supervisor u_sup (.power_cut(power_cut), .ext_reset(ext_reset), .pin_oe(pin_oe),
    .nrst(nrst), .pin_level(pin_level));
  // short nmi timeout keeps the escalation runs brief
  ofs_sequencer #(.NUM_IRQ(8), .NMI_TIMEOUT_CYC(20)) DUT (
    .clock(clock), .nrst(nrst), .warm_reset_pin_in(pin_level), .int_reset_req(int_req),
    .boot_rom_done(rom_done), .app_config_done(app_done), .secure_cfg_done(cfg_done),
    .sec_start_req(start_req), .pri_critical_fault(pri_f), .sec_critical_fault(sec_f),
    .pri_nmi_ack(pri_ack), .sec_nmi_ack(sec_ack), .security_violation(sviol),
    .periph_irq(pirq), .irq_ack(iack), .op_state(op_state), .sec_state(sec_state),
    .init_analog(init_an), .master_cpu_reset(mcr), .secondary_cpu_reset(scr),
    .fetch_boot_rom(fetch), .mem_secure(msec), .safety_enable(safe_en),
    .func_outputs_off(fo_off), .pri_nmi(pri_nmi), .sec_nmi(sec_nmi), .cpu_int(cpu_int),
    .cpu_int_vec(vec), .error_status_pin(err_pin), .warm_reset_pin_out(pin_out),
    .warm_reset_pin_oe(pin_oe), .fault_severity(sev));

  always #2 clock = ~clock;

  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      mismatches = mismatches + 1;
      final_report();
    end
  end

  // ***************************************************
  // helpers
  // ***************************************************
  task final_report;
    if (mismatches == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  task wait_op(input ofs_state_t s, input int lim);
    for (int i = 0; i < lim && op_state !== s; i++) @(negedge clock);
  endtask

  task pulse_fault(input logic pri);
    if (pri) pri_f = 1'b1;
    else sec_f = 1'b1;
    tick(1);
    pri_f = 1'b0;
    sec_f = 1'b0;
    tick(3);
  endtask

  task boot_quick;
    {rom_done, cfg_done, app_done, start_req} = 4'hf;
    wait_op(OFS_OPERATIONAL, 200);
    tick(4);
  endtask

  // ***************************************************
  // scenarios
  // ***************************************************
  task s_boot;
    wait_op(OFS_COLD_BOOT, 20);
    chk(op_state, OFS_COLD_BOOT);
    chk({init_an, mcr}, 2'b11);
    app_done = 1'b1;
    start_req = 1'b1;
    wait_op(OFS_WARM_BOOT, 110);
    chk({op_state, mcr, fetch, msec}, {OFS_WARM_BOOT, 3'b011});
    tick(4);
    chk({op_state, scr}, {OFS_WARM_BOOT, 1'b1});
    app_done = 1'b0;
    rom_done = 1'b1;
    cfg_done = 1'b1;
    wait_op(OFS_PRE_OPERATIONAL, 20);
    chk({op_state, msec, safe_en, scr}, {OFS_PRE_OPERATIONAL, 3'b001});
    app_done = 1'b1;
    wait_op(OFS_OPERATIONAL, 20);
    tick(4);
    chk({op_state, safe_en, scr}, {OFS_OPERATIONAL, 2'b10});
  endtask

  task s_irq_fault;
    pirq = 8'h0c;
    tick(1);
    pirq = 8'h00;
    tick(3);
    chk({cpu_int, vec}, {1'b1, 5'h02});
    iack = 1'b1;
    tick(1);
    iack = 1'b0;
    tick(3);
    chk(vec, 5'h03);
    pulse_fault(1'b1);
    chk({pri_nmi, err_pin, vec}, {2'b11, OFS_VEC_NMI});
    chk({op_state, fo_off}, {OFS_SAFE, 1'b1});
    pri_ack = 1'b1;
    tick(1);
    pri_ack = 1'b0;
    tick(3);
    chk({pri_nmi, op_state}, {1'b0, OFS_SAFE});
    iack = 1'b1;
    tick(1);
    iack = 1'b0;
    tick(3);
    chk(cpu_int, 1'b0);
    ext_reset = 1'b1;
    wait_op(OFS_RESET, 10);
    chk(op_state, OFS_RESET);
    ext_reset = 1'b0;
  endtask

  task s_secviol;
    rom_done = 1'b0;
    sviol = 1'b1;
    tick(1);
    sviol = 1'b0;
    wait_op(OFS_WARM_BOOT, 5);
    chk({op_state, mcr, fetch}, {OFS_WARM_BOOT, 2'b01});
    rom_done = 1'b1;
    wait_op(OFS_OPERATIONAL, 20);
    chk(op_state, OFS_OPERATIONAL);
    tick(4);
  endtask

  task s_sec_nmi;
    pulse_fault(1'b0);
    chk({sec_nmi, err_pin, op_state}, {2'b11, OFS_SAFE});
    for (int i = 0; i < 30 && sec_state !== OFS_WARM_BOOT; i++) @(negedge clock);
    chk({sec_state, pin_oe, sev}, {OFS_WARM_BOOT, 1'b0, OFS_SEV_CPU_RESET});
    tick(2);
    chk({sec_nmi, scr, sec_state}, {2'b00, OFS_OPERATIONAL});
    int_req = 1'b1;
    tick(1);
    int_req = 1'b0;
    wait_op(OFS_RESET, 5);
    chk(op_state, OFS_RESET);
  endtask

  task s_warm;
    pulse_fault(1'b1);
    for (int i = 0; i < 40 && pin_oe !== 1'b1; i++) @(negedge clock);
    tick(2);
    chk({pin_oe, pin_level}, 2'b10);
    chk(sev, OFS_SEV_WARM_RESET);
    wait_op(OFS_RESET, 10);
    chk(op_state, OFS_RESET);
    wait_op(OFS_COLD_BOOT, 80);
    chk(op_state, OFS_COLD_BOOT);
  endtask

  task s_power;
    power_cut = 1'b1;
    tick(2);
    chk({op_state, mcr, fo_off}, {OFS_POWERED_OFF, 2'b11});
    power_cut = 1'b0;
    wait_op(OFS_COLD_BOOT, 20);
    chk(op_state, OFS_COLD_BOOT);
  endtask

  initial begin
    power_cut = 1'b1;
    {ext_reset, rom_done, cfg_done, app_done, start_req, int_req} = 6'h00;
    {pri_f, sec_f, pri_ack, sec_ack, sviol, iack} = 6'h00;
    pirq = 8'h00;
    tick(2);
    power_cut = 1'b0;
    s_boot();
    s_irq_fault();
    boot_quick();
    s_secviol();
    s_sec_nmi();
    boot_quick();
    s_warm();
    boot_quick();
    s_power();
    final_report();
  end
endmodule // operating_state_fault_sequencer_test
